// file: include/temp_sensor_pkg.sv
package temp_sensor_pkg;

    // ****************************************************************
    // Register map on the special function register bus.
    // ****************************************************************
    localparam logic [7:0] CTRL_ADDR = 8'hD2;
    localparam logic [7:0] CTRL_PAGE = 8'h0F;
    localparam logic [7:0] RES_LOW_ADDR = 8'hD2;
    localparam logic [7:0] RES_HIGH_ADDR = 8'hD3;
    localparam logic [7:0] RES_PAGE = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] RES_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ****************************************************************
    // Field layout of the control register and the result word.
    // ****************************************************************
    localparam int START_BIT = 7;
    localparam int DONE_BIT = 6;
    localparam int LEN_MSB = 2;
    localparam int LEN_LSB = 0;
    localparam int LEN_W = LEN_MSB - LEN_LSB + 1;
    localparam logic [2:0] RSV_READ = 3'h0;
    localparam int RESULT_W = 16;
    localparam int FRAC_BITS = 7;

    // ****************************************************************
    // Timing of one measurement.
    // ****************************************************************
    localparam int SENSOR_BLOCK = 256;
    localparam int FIXED_TIME_US = 32;
    localparam int CLK_FREQ_MHZ = 20;
    localparam int FIXED_CYCLES = FIXED_TIME_US * CLK_FREQ_MHZ;
    localparam int SENSE_CNT_W = 17;

    // ****************************************************************
    // Measurement sequencer states, Gray coded along the path.
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SENSE = 2'b01,
        ST_SETTLE = 2'b11
    } meas_state_t;

endpackage

// file: design/bit_sync.sv
`timescale 1ns/10ps

// Two flip-flop synchroniser for signals arriving from outside the clock domain.
module bit_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncFf
);

    logic [WIDTH-1:0] stageOneFf;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stageOneFf <= '0;
            syncFf <= '0;
        end else begin
            stageOneFf <= asyncIn;
            syncFf <= stageOneFf;
        end
    end

endmodule

// file: design/die_temp_sensor_control.sv
`timescale 1ns/10ps

// Function
// - Start runs on start bit set then cleared.
// - Completion sets the finished flag bit six.
// - Enabled interrupt fires when finished flag sets.
// - Hardware never clears finished flag; software does.
// - Length is 256 sensor periods scaled plus 32us.
// - High result register holds the word's top byte.
// - Low result register holds the word's bottom byte.
// - Control register decodes at 0xD2 page F.
// - High result decodes at 0xD3 page 0.
// - Low result decodes at 0xD2 page 0.
// - Result is sign, eight integer, seven fraction bits.
// - Result is readable when the flag sets.
module die_temp_sensor_control
    import temp_sensor_pkg::*;
#(
    parameter int SETTLE_CYCLES = FIXED_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] sfrAddr,
    input wire logic [7:0] sfrPage,
    input wire logic sfrWrite,
    input wire logic [7:0] sfrWdata,
    output logic [7:0] sfrRdata,
    input wire logic sensorClock,
    input wire logic [RESULT_W-1:0] sensorWord,
    input wire logic tempIrqEnable,
    output logic tempIrq
);

    localparam int FIX_W = $clog2(SETTLE_CYCLES + 1);
    localparam logic [FIX_W-1:0] FIX_LAST = FIX_W'(SETTLE_CYCLES - 1);

    // ****************************************************************
    // Elaboration checks.
    // ****************************************************************
    if (SETTLE_CYCLES < 1) begin : g_bad_settle
        $error("SETTLE_CYCLES must be at least one");
    end

    // ****************************************************************
    // Declarations.
    // ****************************************************************
    meas_state_t stateFf;
    logic startFf;
    logic doneFf;
    logic [LEN_W-1:0] lenFf;
    logic [LEN_W-1:0] activeLenFf;
    logic [SENSE_CNT_W-1:0] senseCntFf;
    logic [SENSE_CNT_W-1:0] senseTarget;
    logic [FIX_W-1:0] fixCntFf;
    logic [7:0] resultHighFf;
    logic [7:0] resultLowFf;
    logic [7:0] rdataFf;
    logic irqFf;
    logic sensorSyncFf;
    logic sensorPrevFf;
    logic sensorRise;
    logic [RESULT_W-1:0] wordSyncFf;
    logic wrCtrl;
    logic wrHigh;
    logic wrLow;
    logic startTrigger;
    logic senseLast;
    logic finishPulse;
    logic clearDone;

    // ****************************************************************
    // Input synchronisers for the sensor clock and the sensor word.
    // ****************************************************************
    bit_sync #(.WIDTH(1)) u_clk_sync (
        .clk(clk),
        .rst_n(rst_n),
        .asyncIn(sensorClock),
        .syncFf(sensorSyncFf)
    );

    bit_sync #(.WIDTH(RESULT_W)) u_word_sync (
        .clk(clk),
        .rst_n(rst_n),
        .asyncIn(sensorWord),
        .syncFf(wordSyncFf)
    );

    // Previous synchronised sensor clock level for edge detection.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sensorPrevFf <= 1'b0;
        end else begin
            sensorPrevFf <= sensorSyncFf;
        end
    end

    // ****************************************************************
    // Register decode and control strobes.
    // ****************************************************************
    always_comb begin
        wrCtrl = 1'b0;
        wrHigh = 1'b0;
        wrLow = 1'b0;
        if (sfrWrite && sfrPage == CTRL_PAGE && sfrAddr == CTRL_ADDR) begin
            wrCtrl = 1'b1;
        end else if (sfrWrite && sfrPage == RES_PAGE && sfrAddr == RES_HIGH_ADDR) begin
            wrHigh = 1'b1;
        end else if (sfrWrite && sfrPage == RES_PAGE && sfrAddr == RES_LOW_ADDR) begin
            wrLow = 1'b1;
        end
    end

    // A measurement launches when a write clears a start bit that was set.
    assign startTrigger = wrCtrl && startFf && !sfrWdata[START_BIT];
    assign sensorRise = sensorSyncFf && !sensorPrevFf;
    // Sensor periods needed: 256 times (2^(len+1) + 1).
    assign senseTarget = SENSE_CNT_W'(SENSOR_BLOCK * ((1 << (int'(activeLenFf) + 1)) + 1));
    assign senseLast = stateFf == ST_SENSE && sensorRise && senseCntFf == senseTarget - 1'b1;
    assign finishPulse = stateFf == ST_SETTLE && fixCntFf == FIX_LAST;
    assign clearDone = wrCtrl && !sfrWdata[DONE_BIT];

    // ****************************************************************
    // Control register fields.
    // ****************************************************************
    // Start and length bits are plain software storage; reserved bits are not kept.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            startFf <= CTRL_RESET[START_BIT];
            lenFf <= CTRL_RESET[LEN_MSB:LEN_LSB];
        end else if (wrCtrl) begin
            startFf <= sfrWdata[START_BIT];
            lenFf <= sfrWdata[LEN_MSB:LEN_LSB];
        end
    end

    // Finished flag: hardware only sets it, and a set beats a same-cycle clear.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            doneFf <= CTRL_RESET[DONE_BIT];
        end else if (finishPulse) begin
            doneFf <= 1'b1;
        end else if (clearDone) begin
            doneFf <= 1'b0;
        end
    end

    // ****************************************************************
    // Measurement sequencer.
    // ****************************************************************
    // Counts sensor periods, then the fixed settle time; a start while busy is ignored.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stateFf <= ST_IDLE;
            activeLenFf <= CTRL_RESET[LEN_MSB:LEN_LSB];
            senseCntFf <= '0;
            fixCntFf <= '0;
        end else begin
            case (stateFf)
                ST_IDLE: begin
                    if (startTrigger) begin
                        stateFf <= ST_SENSE;
                        activeLenFf <= sfrWdata[LEN_MSB:LEN_LSB];
                        senseCntFf <= '0;
                    end
                end
                ST_SENSE: begin
                    if (senseLast) begin
                        stateFf <= ST_SETTLE;
                        fixCntFf <= '0;
                    end else if (sensorRise) begin
                        senseCntFf <= senseCntFf + 1'b1;
                    end
                end
                ST_SETTLE: begin
                    if (finishPulse) begin
                        stateFf <= ST_IDLE;
                    end else begin
                        fixCntFf <= fixCntFf + 1'b1;
                    end
                end
                default: begin
                    stateFf <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Result registers.
    // ****************************************************************
    // The word is captured together with the flag set; software may also write.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            resultHighFf <= RES_RESET;
            resultLowFf <= RES_RESET;
        end else if (finishPulse) begin
            resultHighFf <= wordSyncFf[RESULT_W-1:8];
            resultLowFf <= wordSyncFf[7:0];
        end else begin
            if (wrHigh) begin
                resultHighFf <= sfrWdata;
            end
            if (wrLow) begin
                resultLowFf <= sfrWdata;
            end
        end
    end

    // Read data follows the address one clock later; unmapped reads give zero.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdataFf <= UNMAPPED_READ;
        end else if (sfrPage == CTRL_PAGE && sfrAddr == CTRL_ADDR) begin
            rdataFf <= {startFf, doneFf, RSV_READ, lenFf};
        end else if (sfrPage == RES_PAGE && sfrAddr == RES_HIGH_ADDR) begin
            rdataFf <= resultHighFf;
        end else if (sfrPage == RES_PAGE && sfrAddr == RES_LOW_ADDR) begin
            rdataFf <= resultLowFf;
        end else begin
            rdataFf <= UNMAPPED_READ;
        end
    end

    // Interrupt pulse coincides with the flag becoming set.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irqFf <= 1'b0;
        end else begin
            irqFf <= finishPulse && tempIrqEnable;
        end
    end

    assign sfrRdata = rdataFf;
    assign tempIrq = irqFf;

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    start_launch_a: assert property (@(posedge clk) disable iff (!rst_n)
        stateFf == ST_IDLE && startTrigger |=> stateFf == ST_SENSE && activeLenFf == $past(sfrWdata[LEN_MSB:LEN_LSB]))
        else $error("Start sequence did not launch a measurement");

    idle_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        stateFf == ST_IDLE && !startTrigger |=> stateFf == ST_IDLE)
        else $error("Measurement began without the start sequence");

    done_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        finishPulse |=> doneFf && stateFf == ST_IDLE)
        else $error("Finished flag not set on completion");

    irq_timing_a: assert property (@(posedge clk) disable iff (!rst_n)
        finishPulse && tempIrqEnable |=> tempIrq && doneFf ##1 !tempIrq)
        else $error("Interrupt not a single pulse with the flag");

    done_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
        doneFf && !clearDone |=> doneFf)
        else $error("Finished flag dropped without a software clear");

    one_ignored_a: assert property (@(posedge clk) disable iff (!rst_n)
        !doneFf && !finishPulse && wrCtrl && sfrWdata[DONE_BIT] |=> !doneFf)
        else $error("Writing one changed the finished flag");

    sense_span_a: assert property (@(posedge clk) disable iff (!rst_n)
        stateFf == ST_SENSE ##1 stateFf == ST_SETTLE |-> $past(senseCntFf) == senseTarget - 1'b1)
        else $error("Sensor period count wrong for the length field");

    settle_span_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(stateFf == ST_SETTLE) |-> fixCntFf == '0)
        else $error("Settle phase did not start from zero");

    settle_step_a: assert property (@(posedge clk) disable iff (!rst_n)
        stateFf == ST_SETTLE && !finishPulse |=> stateFf == ST_SETTLE && fixCntFf == $past(fixCntFf) + 1'b1)
        else $error("Settle phase left early or skipped a count");

    result_high_a: assert property (@(posedge clk) disable iff (!rst_n)
        finishPulse |=> resultHighFf == $past(wordSyncFf[RESULT_W-1:8]))
        else $error("High result byte not captured");

    result_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        finishPulse |=> resultLowFf == $past(wordSyncFf[7:0]) && doneFf)
        else $error("Low result byte not captured with the flag");

    ctrl_decode_a: assert property (@(posedge clk) disable iff (!rst_n)
        sfrPage == CTRL_PAGE && sfrAddr == CTRL_ADDR |=> sfrRdata == {$past(startFf), $past(doneFf), RSV_READ, $past(lenFf)})
        else $error("Control register read wrong");

    high_decode_a: assert property (@(posedge clk) disable iff (!rst_n)
        sfrPage == RES_PAGE && sfrAddr == RES_HIGH_ADDR |=> sfrRdata == $past(resultHighFf))
        else $error("High result read wrong");

    low_decode_a: assert property (@(posedge clk) disable iff (!rst_n)
        sfrPage == RES_PAGE && sfrAddr == RES_LOW_ADDR |=> sfrRdata == $past(resultLowFf))
        else $error("Low result read wrong");

endmodule

// file: bench/tb.sv
`timescale 1ns/10ps

// ****************************************************************
// Self-checking bench for the die temperature sensor control block.
// ****************************************************************
module tb
    import temp_sensor_pkg::*;
;
    localparam int SETTLE = 4;
    localparam int SENSE_DIV = 3;
    logic clk = 1'b0;
    logic rstN;
    logic [7:0] sfrAddr;
    logic [7:0] sfrPage;
    logic sfrWrite;
    logic [7:0] sfrWdata;
    logic [7:0] sfrRdata;
    logic sensorClock = 1'b0;
    logic [15:0] sensorWord;
    logic tempIrqEnable;
    logic tempIrq;
    int failures = 0;
    int checkCount = 0;
    int irqSeen = 0;
    int phase = 0;
    logic [31:0] seed = 32'h0000_5A7A;
    logic [15:0] wordQ[$];

    die_temp_sensor_control #(.SETTLE_CYCLES(SETTLE)) u_die_temp_sensor_control (
        .clk(clk),
        .rst_n(rstN),
        .sfrAddr(sfrAddr),
        .sfrPage(sfrPage),
        .sfrWrite(sfrWrite),
        .sfrWdata(sfrWdata),
        .sfrRdata(sfrRdata),
        .sensorClock(sensorClock),
        .sensorWord(sensorWord),
        .tempIrqEnable(tempIrqEnable),
        .tempIrq(tempIrq)
    );

    // The system clock toggles every half period of 25 ns.
    always #25 clk = ~clk;

    // The sensor clock runs at a third of the system clock, below the synchroniser limit.
    always @(negedge clk) begin
        phase <= (phase == SENSE_DIV - 1) ? 0 : phase + 1;
        sensorClock <= (phase == SENSE_DIV - 1);
    end

    // Interrupt pulses last one cycle, so each one is counted at the falling edge.
    always @(negedge clk) begin
        if (tempIrq === 1'b1) begin
            irqSeen <= irqSeen + 1;
        end
    end

    // Xorshift generator for the random stimulus.
    function automatic logic [31:0] nextRand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Compares one observed value with its expectation and counts the result.
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checkCount++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic close_out();
        if (failures == 0 && checkCount > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // One register write followed by an idle cycle, so the strobe never toggles twice in one step.
    task automatic wr(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] dt);
        sfrPage = pg;
        sfrAddr = ad;
        sfrWdata = dt;
        sfrWrite = 1'b1;
        @(negedge clk);
        sfrWrite = 1'b0;
        @(negedge clk);
    endtask

    // One register read; the registered data is settled at the next falling edge.
    task automatic rd(input logic [7:0] pg, input logic [7:0] ad, output logic [7:0] dt);
        sfrPage = pg;
        sfrAddr = ad;
        @(negedge clk);
        dt = sfrRdata;
    endtask

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        logic [7:0] d;
        logic [31:0] r;
        logic [15:0] w;
        logic done;
        int edges;
        int elapsed;
        int irqBase;
        realtime t0;
        rstN = 1'b0;
        sfrAddr = 8'h00;
        sfrPage = 8'h00;
        sfrWrite = 1'b0;
        sfrWdata = 8'h00;
        sensorWord = 16'h0000;
        tempIrqEnable = 1'b0;
        repeat (4) @(negedge clk);
        rstN = 1'b1;
        repeat (3) @(negedge clk);
        // Reset values, page decode and unmapped places.
        rd(CTRL_PAGE, CTRL_ADDR, d);
        check("ctrl reset", d, CTRL_RESET);
        rd(RES_PAGE, RES_LOW_ADDR, d);
        check("low reset", d, RES_RESET);
        rd(RES_PAGE, RES_HIGH_ADDR, d);
        check("high reset", d, RES_RESET);
        rd(CTRL_PAGE, RES_HIGH_ADDR, d);
        check("unmapped", d, UNMAPPED_READ);
        // Finished flag cannot be set by software and reserved bits read zero.
        r = nextRand();
        wr(CTRL_PAGE, CTRL_ADDR, {2'b01, 3'b000, r[2:0]});
        rd(CTRL_PAGE, CTRL_ADDR, d);
        check("ctrl write", d, {5'h00, r[2:0]});
        // Result registers are writable and distinct from the control register.
        wr(RES_PAGE, RES_LOW_ADDR, r[15:8]);
        wr(RES_PAGE, RES_HIGH_ADDR, r[23:16]);
        rd(RES_PAGE, RES_LOW_ADDR, d);
        check("low rw", d, r[15:8]);
        rd(RES_PAGE, RES_HIGH_ADDR, d);
        check("high rw", d, r[23:16]);
        rd(CTRL_PAGE, CTRL_ADDR, d);
        check("ctrl kept", d, {5'h00, r[2:0]});
        // One measurement per conversion length that fits the run time.
        for (int len = 0; len < 5; len++) begin
            r = nextRand();
            sensorWord = r[15:0];
            wordQ.push_back(r[15:0]);
            tempIrqEnable = len[0];
            irqBase = irqSeen;
            edges = 256 * ((1 << (len + 1)) + 1);
            wr(CTRL_PAGE, CTRL_ADDR, 8'h80);
            rd(CTRL_PAGE, CTRL_ADDR, d);
            check("start stored", d, 8'h80);
            t0 = $realtime + 25;
            wr(CTRL_PAGE, CTRL_ADDR, len[7:0]);
            if (len == 2) begin
                repeat (100) @(negedge clk);
                wr(CTRL_PAGE, CTRL_ADDR, 8'h80 | len[7:0]);
                wr(CTRL_PAGE, CTRL_ADDR, len[7:0]);
            end
            done = 1'b0;
            for (int i = 0; i < edges * SENSE_DIV + 400 && !done; i++) begin
                rd(CTRL_PAGE, CTRL_ADDR, d);
                done = (d[DONE_BIT] === 1'b1);
            end
            if (!done) begin
                failures++;
                close_out();
            end
            elapsed = int'(($realtime - t0) / 50.0) - (edges * SENSE_DIV + SETTLE + 1);
            check("duration", 16'(elapsed <= 12 && elapsed >= -12), 16'h0001);
            check("ctrl done", d, {8'h40 | len[7:0]});
            repeat (4) @(negedge clk);
            check("irq count", 16'(irqSeen - irqBase), 16'(len % 2));
            w = wordQ.pop_front();
            rd(RES_PAGE, RES_HIGH_ADDR, d);
            check("result high", d, w[15:8]);
            rd(RES_PAGE, RES_LOW_ADDR, d);
            check("result low", d, w[7:0]);
            repeat (20) @(negedge clk);
            wr(CTRL_PAGE, CTRL_ADDR, 8'h40 | len[7:0]);
            rd(CTRL_PAGE, CTRL_ADDR, d);
            check("done held", d, {8'h40 | len[7:0]});
            wr(CTRL_PAGE, CTRL_ADDR, len[7:0]);
            rd(CTRL_PAGE, CTRL_ADDR, d);
            check("done cleared", d, len[7:0]);
        end
        close_out();
    end
endmodule
